// ==== logic/wdrl_params.svh ====
// Register offsets, reset values and timing counts for the watchdog reload/lock block
`ifndef WDRL_PARAMS_SVH
`define WDRL_PARAMS_SVH
`define WDRL_ADDR_W 12
`define WDRL_OFS_KEY 12'hff0
`define WDRL_OFS_UPPER 12'hff1
`define WDRL_OFS_MIDDLE 12'hff2
`define WDRL_OFS_LOWER 12'hff3
`define WDRL_OFS_IRQ_STAT 12'hff4
`define WDRL_OFS_IRQ_MASK 12'hff5
`define WDRL_OFS_CTRL 12'hff6
`define WDRL_KEY_FIRST 8'h55
`define WDRL_KEY_SECOND 8'haa
`define WDRL_RST_UPPER 8'h00
`define WDRL_RST_MIDDLE 8'h04
`define WDRL_RST_LOWER 8'h00
`define WDRL_CNT_MAX 24'hffffff
`define WDRL_CNT_NOREFRESH 24'h000002
`define WDRL_CNT_ZERO 24'h000000
`define WDRL_CNT_ONE 24'h000001
`define WDRL_TICK_HZ 10000
`define WDRL_CLK_HZ 25000000
`define WDRL_TICK_DIV (`WDRL_CLK_HZ / `WDRL_TICK_HZ)
`define WDRL_STAT_TIMEOUT 0
`define WDRL_STAT_RESET 1
`define WDRL_STAT_UNLOCK_ERR 2
`endif

// ==== logic/wdrl_pkg.sv ====
// Types shared by the watchdog reload/lock block
package wdrl_pkg;
    // Gray coded along locked, first key, upper, middle, lower
    typedef enum logic [2:0] {
        WDRL_LOCKED = 3'b000,
        WDRL_KEY1 = 3'b001,
        WDRL_OPEN_U = 3'b011,
        WDRL_OPEN_H = 3'b010,
        WDRL_OPEN_L = 3'b110
    } wdrl_lock_e;
endpackage

// ==== logic/wdrl_tick_div.sv ====
// Divider that makes the slow watchdog count enable from the system clock
`timescale 1ns/1ps
`include "wdrl_params.svh"
module wdrl_tick_div (
    input wire logic clk,
    input wire logic sys_rst,
    output logic tickPulse
);
    localparam int Div = `WDRL_TICK_DIV;
    logic [11:0] divCnt_q;
    logic [11:0] divCnt_d;
    logic tick_d;

    // Count down and pulse once per period
    always_comb begin
        tick_d = 1'b0;
        if (divCnt_q == 12'h000) begin
            divCnt_d = 12'(Div - 1);
            tick_d = 1'b1;
        end else begin
            divCnt_d = divCnt_q - 12'h001;
        end
    end

    // Registered so the pulse is glitch free
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            divCnt_q <= 12'(Div - 1);
            tickPulse <= 1'b0;
        end else begin
            divCnt_q <= divCnt_d;
            tickPulse <= tick_d;
        end
    end
endmodule

// ==== logic/wdrl_top.sv ====
// Watchdog reload registers with unlock sequence, down-counter and interrupt status
`timescale 1ns/1ps
`include "wdrl_params.svh"
module wdrl_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic refreshInstruction,
    input wire logic timeoutResponseOption,
    output logic wdtIrq,
    output logic wdtSysReset,
    output logic [7:0] resetCauseRegister
);
    logic tickPulse;
    wdrl_pkg::wdrl_lock_e lock_q;
    wdrl_pkg::wdrl_lock_e lock_d;
    logic [23:0] reload_q;
    logic [23:0] reload_d;
    logic [23:0] count_q;
    logic [23:0] count_d;
    logic enabled_q;
    logic enabled_d;
    logic [2:0] stat_q;
    logic [2:0] stat_d;
    logic [2:0] mask_q;
    logic [2:0] mask_d;
    logic [7:0] rdata_d;
    logic irq_d;
    logic sysRst_d;
    logic timeoutEv;
    logic unlockErrEv;
    logic optSync1_q;
    logic optSync2_q;
    logic [2:0] statSet;
    logic [2:0] statClr;
    logic [7:0] cause_d;

    wdrl_tick_div u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .tickPulse(tickPulse)
    );

    // Option bit is a strap pin, so resync it before use
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            optSync1_q <= 1'b0;
            optSync2_q <= 1'b0;
        end else begin
            optSync1_q <= timeoutResponseOption;
            optSync2_q <= optSync1_q;
        end
    end

    // Lock sequencer and reload byte storage
    always_comb begin
        lock_d = lock_q;
        reload_d = reload_q;
        unlockErrEv = 1'b0;
        if (regWr) begin
            case (lock_q)
                wdrl_pkg::WDRL_LOCKED: begin
                    // Key bytes only step the sequencer, nothing is stored
                    if (regAddr == `WDRL_OFS_KEY && regWdata == `WDRL_KEY_FIRST) begin
                        lock_d = wdrl_pkg::WDRL_KEY1;
                    end else if (regAddr == `WDRL_OFS_UPPER || regAddr == `WDRL_OFS_MIDDLE ||
                                 regAddr == `WDRL_OFS_LOWER) begin
                        unlockErrEv = 1'b1;
                    end
                end
                wdrl_pkg::WDRL_KEY1: begin
                    if (regAddr == `WDRL_OFS_KEY && regWdata == `WDRL_KEY_SECOND) begin
                        lock_d = wdrl_pkg::WDRL_OPEN_U;
                    end else begin
                        lock_d = wdrl_pkg::WDRL_LOCKED;
                    end
                end
                wdrl_pkg::WDRL_OPEN_U: begin
                    if (regAddr == `WDRL_OFS_UPPER) begin
                        reload_d[23:16] = regWdata;
                        lock_d = wdrl_pkg::WDRL_OPEN_H;
                    end else begin
                        lock_d = wdrl_pkg::WDRL_LOCKED;
                    end
                end
                wdrl_pkg::WDRL_OPEN_H: begin
                    if (regAddr == `WDRL_OFS_MIDDLE) begin
                        reload_d[15:8] = regWdata;
                        lock_d = wdrl_pkg::WDRL_OPEN_L;
                    end else begin
                        lock_d = wdrl_pkg::WDRL_LOCKED;
                    end
                end
                wdrl_pkg::WDRL_OPEN_L: begin
                    if (regAddr == `WDRL_OFS_LOWER) begin
                        reload_d[7:0] = regWdata;
                    end
                    // Lower byte closes the window; any other write relocks as well
                    lock_d = wdrl_pkg::WDRL_LOCKED;
                end
                default: begin
                    lock_d = wdrl_pkg::WDRL_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_q <= wdrl_pkg::WDRL_LOCKED;
            reload_q <= {`WDRL_RST_UPPER, `WDRL_RST_MIDDLE, `WDRL_RST_LOWER};
        end else begin
            lock_q <= lock_d;
            reload_q <= reload_d;
        end
    end

    // Down-counter: refresh reloads it, the slow tick counts it down.
    // The first refresh also starts the counter; there is no way to stop it
    // again except a time-out in reset mode or a system reset.
    always_comb begin
        count_d = count_q;
        enabled_d = enabled_q;
        timeoutEv = 1'b0;
        sysRst_d = wdtSysReset;
        // Near the end a late refresh would race the time-out, so it is dropped
        if (refreshInstruction && !(enabled_q && count_q <= `WDRL_CNT_NOREFRESH)) begin
            count_d = reload_q;
            enabled_d = 1'b1;
        end else if (enabled_q && tickPulse) begin
            if (count_q == `WDRL_CNT_ZERO) begin
                // Interrupt mode keeps running from the top instead of reloading
                count_d = `WDRL_CNT_MAX;
            end else begin
                count_d = count_q - `WDRL_CNT_ONE;
            end
            if (count_q == `WDRL_CNT_ONE) begin
                // The count reaches zero on this tick in interrupt mode; reset mode reloads it below
                timeoutEv = 1'b1;
                if (optSync2_q) begin
                    // Reset mode: stop and hold the request until reset arrives
                    count_d = reload_q;
                    enabled_d = 1'b0;
                    sysRst_d = 1'b1;
                end
            end
        end
    end

    // Sticky status with write-one-to-clear, and its mask.
    // A set and a clear in the same cycle leave the bit set, so no event is lost.
    always_comb begin
        statSet = 3'h0;
        statClr = 3'h0;
        mask_d = mask_q;
        statSet[`WDRL_STAT_TIMEOUT] = timeoutEv;
        statSet[`WDRL_STAT_RESET] = timeoutEv && optSync2_q;
        statSet[`WDRL_STAT_UNLOCK_ERR] = unlockErrEv;
        if (regWr && regAddr == `WDRL_OFS_IRQ_STAT) begin
            statClr = regWdata[2:0];
        end
        if (regWr && regAddr == `WDRL_OFS_IRQ_MASK) begin
            mask_d = regWdata[2:0];
        end
        stat_d = (stat_q & ~statClr) | statSet;
        // Level interrupt follows the next status so it needs no extra stage
        irq_d = |(stat_d & mask_d);
    end

    // Read mux; the data stand in the cycle after the read strobe only.
    // Reload addresses show the live count, never the stored reload bytes,
    // so software cannot read back what it programmed.
    always_comb begin
        rdata_d = 8'h00;
        // Cause output lags status by one cycle, the same as a key-port read
        cause_d = {5'h00, stat_q};
        if (regRd) begin
            case (regAddr)
                `WDRL_OFS_KEY: begin
                    rdata_d = {5'h00, stat_q};
                end
                `WDRL_OFS_UPPER: begin
                    rdata_d = count_q[23:16];
                end
                `WDRL_OFS_MIDDLE: begin
                    rdata_d = count_q[15:8];
                end
                `WDRL_OFS_LOWER: begin
                    rdata_d = count_q[7:0];
                end
                `WDRL_OFS_IRQ_STAT: begin
                    rdata_d = {5'h00, stat_q};
                end
                `WDRL_OFS_IRQ_MASK: begin
                    rdata_d = {5'h00, mask_q};
                end
                `WDRL_OFS_CTRL: begin
                    rdata_d = {7'h00, enabled_q};
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // Counter, status and output registers.
    // Every output comes straight from a flip-flop here.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_q <= {`WDRL_RST_UPPER, `WDRL_RST_MIDDLE, `WDRL_RST_LOWER};
            enabled_q <= 1'b0;
            stat_q <= 3'h0;
            mask_q <= 3'h0;
            regRdata <= 8'h00;
            wdtIrq <= 1'b0;
            wdtSysReset <= 1'b0;
            resetCauseRegister <= 8'h00;
        end else begin
            count_q <= count_d;
            enabled_q <= enabled_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            regRdata <= rdata_d;
            wdtIrq <= irq_d;
            wdtSysReset <= sysRst_d;
            resetCauseRegister <= cause_d;
        end
    end
endmodule

// ==== bench/wdrl_top_chk.sv ====
// Port checker for the watchdog reload block
`timescale 1ns/1ps
`include "wdrl_params.svh"
module wdrl_top_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [11:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic refreshInstruction,
    input wire logic timeoutResponseOption,
    input wire logic wdtIrq,
    input wire logic wdtSysReset,
    input wire logic [7:0] resetCauseRegister
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_key_read_cause: assert property (regRd && regAddr == `WDRL_OFS_KEY |=>
        regRdata == resetCauseRegister) else $error("key read not cause");
    a_key_wr_keeps: assert property (regWr && regAddr == `WDRL_OFS_KEY |=>
        $stable(resetCauseRegister)) else $error("key write changed cause");
    a_sysrst_by_option: assert property ($rose(wdtSysReset) |->
        $past(timeoutResponseOption)) else $error("reset in irq mode");
    a_sysrst_mode_low: assert property (!timeoutResponseOption &&
        !$past(timeoutResponseOption) |-> !wdtSysReset) else $error("reset high");
    // Reset checks need their own disable, the default one would mask them
    a_rst_clears_irq: assert property (disable iff (1'b0) sys_rst |=> !wdtIrq)
        else $error("irq after reset");
    a_rst_clears_sys: assert property (disable iff (1'b0) sys_rst |=> !wdtSysReset)
        else $error("system reset after reset");
    a_irq_held: assert property (wdtIrq && !regWr |=> wdtIrq)
        else $error("irq dropped without write");
    a_irq_held_two: assert property (wdtIrq && !regWr ##1 !regWr |=> wdtIrq)
        else $error("irq dropped");
    c_key_read: cover property (regRd && regAddr == `WDRL_OFS_KEY);
    c_refresh: cover property (refreshInstruction ##1 regRd);
    c_key_write: cover property (regWr && regAddr == `WDRL_OFS_KEY);
endmodule
bind wdrl_top wdrl_top_chk i_wdrl_top_chk (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .refreshInstruction(refreshInstruction),
    .timeoutResponseOption(timeoutResponseOption), .wdtIrq(wdtIrq),
    .wdtSysReset(wdtSysReset), .resetCauseRegister(resetCauseRegister));

// ==== bench/testbench.sv ====
// Self-checking bench for the watchdog reload and unlock registers
`timescale 1ns/1ps
`include "wdrl_params.svh"
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin failCount++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module testbench;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic [11:0] regAddr = 12'h000;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata, cause, b;
    logic regWr = 1'b0, regRd = 1'b0, refresh = 1'b0, irq, sysReset;
    logic opt = 1'b0;
    int failCount = 0, nCompared = 0, cycles = 0;
    always #20 clk = ~clk;
    wdrl_top i_wdrl_top (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .refreshInstruction(refresh),
        .timeoutResponseOption(opt), .wdtIrq(irq), .wdtSysReset(sysReset),
        .resetCauseRegister(cause));
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    // Refresh, then read the live count back through the reload addresses
    task automatic count(input logic [23:0] e);
        logic [23:0] c;
        @(posedge clk);
        refresh <= 1'b1;
        @(posedge clk);
        refresh <= 1'b0;
        rd(`WDRL_OFS_UPPER, c[23:16]);
        rd(`WDRL_OFS_MIDDLE, c[15:8]);
        rd(`WDRL_OFS_LOWER, c[7:0]);
        if (c === e - 24'h1) c = e; // A slow tick may land before the reads
        `CHK(c, e)
    endtask
    task automatic unlock();
        wr(`WDRL_OFS_KEY, `WDRL_KEY_FIRST);
        wr(`WDRL_OFS_KEY, `WDRL_KEY_SECOND);
    endtask
    task automatic testDone();
        $display("compared %0d wrong %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Two time-out waits of 13000 cycles each plus register traffic
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failCount++;
            testDone();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        sysRst <= 1'b0;
        count({`WDRL_RST_UPPER, `WDRL_RST_MIDDLE, `WDRL_RST_LOWER});
        wr(`WDRL_OFS_UPPER, 8'h12);
        count(24'h000400);
        unlock();
        wr(`WDRL_OFS_UPPER, 8'h01);
        wr(`WDRL_OFS_MIDDLE, 8'h23);
        wr(`WDRL_OFS_LOWER, 8'h45);
        count(24'h012345);
        wr(`WDRL_OFS_UPPER, 8'h77);
        count(24'h012345);
        unlock();
        wr(`WDRL_OFS_UPPER, 8'h02);
        wr(`WDRL_OFS_MIDDLE, 8'h03);
        wr(`WDRL_OFS_IRQ_STAT, 8'h00); // Stray write must relock before the low byte
        wr(`WDRL_OFS_LOWER, 8'h0c);
        count(24'h020345);
        rd(`WDRL_OFS_KEY, b);
        `CHK(b, 8'h04)
        `CHK(cause, 8'h04)
        wr(`WDRL_OFS_IRQ_MASK, 8'h04);
        #1 `CHK(irq, 1'b1)
        wr(`WDRL_OFS_IRQ_STAT, 8'h04);
        #1 `CHK(irq, 1'b0)
        unlock();
        wr(`WDRL_OFS_UPPER, 8'h00);
        wr(`WDRL_OFS_MIDDLE, 8'h00);
        wr(`WDRL_OFS_LOWER, 8'h04);
        wr(`WDRL_OFS_IRQ_MASK, 8'h01);
        count(24'h000004);
        repeat (13000) @(posedge clk);
        #1 `CHK(irq, 1'b1)
        `CHK(sysReset, 1'b0)
        rd(`WDRL_OFS_UPPER, b);
        `CHK(b, 8'hff)
        opt <= 1'b1;
        count(24'h000004);
        repeat (13000) @(posedge clk);
        #1 `CHK(sysReset, 1'b1)
        rd(`WDRL_OFS_KEY, b);
        `CHK(b[1], 1'b1)
        @(posedge clk);
        sysRst <= 1'b1;
        repeat (3) @(posedge clk);
        sysRst <= 1'b0;
        #1 `CHK(sysReset, 1'b0)
        `CHK(irq, 1'b0)
        count({`WDRL_RST_UPPER, `WDRL_RST_MIDDLE, `WDRL_RST_LOWER});
        testDone();
    end
endmodule
